// *** design/bss_regs.vh ***
// register offsets, field positions and reset values of the status block
`ifndef BSS_REGS_VH
`define BSS_REGS_VH

// apb address width and byte offsets
`define BSS_ADDR_W 8
`define BSS_OFF_SEC_STATUS 8'h1C
`define BSS_OFF_BRIDGE_CTRL 8'h3C
`define BSS_OFF_MODE_CFG 8'h40

// secondary status field positions
`define BSS_BIT_66MHZ 21
`define BSS_BIT_FBB 23
`define BSS_BIT_MDPE 24
`define BSS_BIT_TSEL_LO 25
`define BSS_BIT_TSEL_HI 26
`define BSS_BIT_STA 27
`define BSS_BIT_RTA 28
`define BSS_BIT_RMA 29
`define BSS_BIT_RSE 30
`define BSS_BIT_DPE 31

// number of sticky error flags and their index
`define BSS_NFLAGS 6
`define BSS_FLG_MDPE 0
`define BSS_FLG_STA 1
`define BSS_FLG_RTA 2
`define BSS_FLG_RMA 3
`define BSS_FLG_RSE 4
`define BSS_FLG_DPE 5

// fixed field values
`define BSS_TSEL_FWD 2'h1
`define BSS_TSEL_REV 2'h0

// bridge control field
`define BSS_BIT_PERR_EN 16

// mode configuration fields
`define BSS_BIT_REVERSE 0
`define BSS_BIT_SEC_PCIX 1

// reset values
`define BSS_RST_PERR_EN 1'b0
`define BSS_RST_REVERSE 1'b0
`define BSS_RST_SEC_PCIX 1'b0
`define BSS_RST_FLAG 1'b0

`endif

// *** design/bss_flag.v ***
// one sticky error flag, set by hardware and cleared by software
`default_nettype none
`include "bss_regs.vh"

module bss_flag (
    // clock and reset
    input wire clk,
    input wire rst,
    // set and clear
    input wire set_evt,
    input wire clr,
    // flag state
    output reg flag_r
);

// --------------------------------------------------------------
// next value
// --------------------------------------------------------------
reg flag_nxt;

always @* begin
    flag_nxt = flag_r;
    if (set_evt) begin
        flag_nxt = 1'b1;
    end else if (clr) begin
        flag_nxt = 1'b0;
    end
end

// --------------------------------------------------------------
// storage
// --------------------------------------------------------------
always @(posedge clk or posedge rst) begin
    if (rst) begin
        flag_r <= `BSS_RST_FLAG;
    end else begin
        flag_r <= flag_nxt;
    end
end

endmodule

`default_nettype wire

// *** design/bss_top.v ***
// secondary status register block of the bridge with apb access
//
// Function
// - bit 21 always reads one, 66 MHz
// - bit 23 one forward in pci mode
// - bit 24 sets only when parity response enabled
// - forward: read, write or split parity sets 24
// - reverse: poisoned completion or write sets 24
// - bits 26:25 read 01 forward, 00 reverse
// - signalled target or completer abort sets 27
// - received target or completer abort sets 28
// - master abort or unsupported request sets 29
// - system error or error message sets 30
// - detected parity (forward) or poisoned tlp (reverse) sets 31
// - parity response enable, bit 16, resets zero
//
// Our own choice: the APB slave port.
`default_nettype none
`include "bss_regs.vh"

module bss_top (
    // clock and reset
    input wire clk,
    input wire rst,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`BSS_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata_r,
    output reg pready_r,
    output reg pslverr_r,
    // forward mode master data parity events
    input wire fwd_rd_parity_err,
    input wire fwd_wr_data_phase,
    input wire secondary_parity_error_in,
    input wire fwd_split_msg_perr,
    // reverse mode master data parity events
    input wire rev_cpl_poisoned,
    input wire rev_wr_poisoned,
    // signalled abort events
    input wire fwd_target_abort_sig,
    input wire rev_cpl_abort_sent,
    // received abort events
    input wire fwd_target_abort_det,
    input wire rev_cpl_abort_recv,
    // master abort and unsupported request events
    input wire fwd_master_abort,
    input wire rev_ur_recv,
    // system error events
    input wire fwd_sys_err_seen,
    input wire rev_err_msg_recv,
    // detected parity events
    input wire fwd_parity_err,
    input wire rev_poisoned_tlp,
    // configuration seen by the rest of the bridge
    output reg parity_resp_en_r,
    output reg reverse_mode_r,
    output reg sec_pcix_mode_r
);

// --------------------------------------------------------------
// apb decode
// --------------------------------------------------------------
wire setup_phase;
wire access_done;
wire wr_done;
wire hit_status;
wire hit_ctrl;
wire hit_mode;
wire hit_any;

assign setup_phase = psel & ~penable;
assign access_done = psel & penable & pready_r;
assign wr_done = access_done & pwrite;
assign hit_status = (paddr == `BSS_OFF_SEC_STATUS);
assign hit_ctrl = (paddr == `BSS_OFF_BRIDGE_CTRL);
assign hit_mode = (paddr == `BSS_OFF_MODE_CFG);
assign hit_any = hit_status | hit_ctrl | hit_mode;

// --------------------------------------------------------------
// write strobes
// --------------------------------------------------------------
wire wr_status_hi;
wire wr_ctrl_lane2;
wire wr_mode_lane0;

assign wr_status_hi = wr_done & hit_status & pstrb[3];
assign wr_ctrl_lane2 = wr_done & hit_ctrl & pstrb[2];
assign wr_mode_lane0 = wr_done & hit_mode & pstrb[0];

// --------------------------------------------------------------
// control registers
// --------------------------------------------------------------
reg parity_resp_en_nxt;
reg reverse_mode_nxt;
reg sec_pcix_mode_nxt;

always @* begin
    parity_resp_en_nxt = parity_resp_en_r;
    reverse_mode_nxt = reverse_mode_r;
    sec_pcix_mode_nxt = sec_pcix_mode_r;
    if (wr_ctrl_lane2) begin
        parity_resp_en_nxt = pwdata[`BSS_BIT_PERR_EN];
    end
    if (wr_mode_lane0) begin
        reverse_mode_nxt = pwdata[`BSS_BIT_REVERSE];
        sec_pcix_mode_nxt = pwdata[`BSS_BIT_SEC_PCIX];
    end
end

always @(posedge clk or posedge rst) begin
    if (rst) begin
        parity_resp_en_r <= `BSS_RST_PERR_EN;
        reverse_mode_r <= `BSS_RST_REVERSE;
        sec_pcix_mode_r <= `BSS_RST_SEC_PCIX;
    end else begin
        parity_resp_en_r <= parity_resp_en_nxt;
        reverse_mode_r <= reverse_mode_nxt;
        sec_pcix_mode_r <= sec_pcix_mode_nxt;
    end
end

// --------------------------------------------------------------
// event qualification by bridge mode
// --------------------------------------------------------------
wire fwd;
wire fwd_wr_perr;
wire mdpe_fwd_evt;
wire mdpe_rev_evt;
wire mdpe_raw;
wire [`BSS_NFLAGS-1:0] set_vec;

assign fwd = ~reverse_mode_r;
assign fwd_wr_perr = fwd_wr_data_phase & secondary_parity_error_in;
assign mdpe_fwd_evt = fwd_rd_parity_err | fwd_wr_perr |
    fwd_split_msg_perr;
assign mdpe_rev_evt = rev_cpl_poisoned | rev_wr_poisoned;
assign mdpe_raw = fwd ? mdpe_fwd_evt : mdpe_rev_evt;

// master data parity error, gated by the response enable
assign set_vec[`BSS_FLG_MDPE] = mdpe_raw & parity_resp_en_r;

// signalled target abort
assign set_vec[`BSS_FLG_STA] = fwd ? fwd_target_abort_sig :
    rev_cpl_abort_sent;

// received target abort
assign set_vec[`BSS_FLG_RTA] = fwd ? fwd_target_abort_det :
    rev_cpl_abort_recv;

// received master abort
assign set_vec[`BSS_FLG_RMA] = fwd ? fwd_master_abort :
    rev_ur_recv;

// received system error
assign set_vec[`BSS_FLG_RSE] = fwd ? fwd_sys_err_seen :
    rev_err_msg_recv;

// detected parity error, not gated by the response enable
assign set_vec[`BSS_FLG_DPE] = fwd ? fwd_parity_err :
    rev_poisoned_tlp;

// --------------------------------------------------------------
// sticky error flags
// --------------------------------------------------------------
wire [`BSS_NFLAGS-1:0] clr_vec;
wire [`BSS_NFLAGS-1:0] flag_vec;

// write one to clear, zero leaves the flag alone
assign clr_vec[`BSS_FLG_MDPE] = wr_status_hi &
    pwdata[`BSS_BIT_MDPE];
assign clr_vec[`BSS_FLG_STA] = wr_status_hi &
    pwdata[`BSS_BIT_STA];
assign clr_vec[`BSS_FLG_RTA] = wr_status_hi &
    pwdata[`BSS_BIT_RTA];
assign clr_vec[`BSS_FLG_RMA] = wr_status_hi &
    pwdata[`BSS_BIT_RMA];
assign clr_vec[`BSS_FLG_RSE] = wr_status_hi &
    pwdata[`BSS_BIT_RSE];
assign clr_vec[`BSS_FLG_DPE] = wr_status_hi &
    pwdata[`BSS_BIT_DPE];

// --------------------------------------------------------------
// one flag instance per sticky error bit
// --------------------------------------------------------------
// master data parity error, bit 24
bss_flag u_flag_mdpe (
    .clk(clk),
    .rst(rst),
    .set_evt(set_vec[`BSS_FLG_MDPE]),
    .clr(clr_vec[`BSS_FLG_MDPE]),
    .flag_r(flag_vec[`BSS_FLG_MDPE])
);

// signalled target abort, bit 27
bss_flag u_flag_sta (
    .clk(clk),
    .rst(rst),
    .set_evt(set_vec[`BSS_FLG_STA]),
    .clr(clr_vec[`BSS_FLG_STA]),
    .flag_r(flag_vec[`BSS_FLG_STA])
);

// received target abort, bit 28
bss_flag u_flag_rta (
    .clk(clk),
    .rst(rst),
    .set_evt(set_vec[`BSS_FLG_RTA]),
    .clr(clr_vec[`BSS_FLG_RTA]),
    .flag_r(flag_vec[`BSS_FLG_RTA])
);

// received master abort, bit 29
bss_flag u_flag_rma (
    .clk(clk),
    .rst(rst),
    .set_evt(set_vec[`BSS_FLG_RMA]),
    .clr(clr_vec[`BSS_FLG_RMA]),
    .flag_r(flag_vec[`BSS_FLG_RMA])
);

// received system error, bit 30
bss_flag u_flag_rse (
    .clk(clk),
    .rst(rst),
    .set_evt(set_vec[`BSS_FLG_RSE]),
    .clr(clr_vec[`BSS_FLG_RSE]),
    .flag_r(flag_vec[`BSS_FLG_RSE])
);

// detected parity error, bit 31
bss_flag u_flag_dpe (
    .clk(clk),
    .rst(rst),
    .set_evt(set_vec[`BSS_FLG_DPE]),
    .clr(clr_vec[`BSS_FLG_DPE]),
    .flag_r(flag_vec[`BSS_FLG_DPE])
);

// --------------------------------------------------------------
// fixed capability fields
// --------------------------------------------------------------
wire cap_66mhz;
wire cap_fbb;
wire [1:0] tsel_timing;

assign cap_66mhz = 1'b1;
assign cap_fbb = fwd & ~sec_pcix_mode_r;
assign tsel_timing = fwd ? `BSS_TSEL_FWD : `BSS_TSEL_REV;

// --------------------------------------------------------------
// read data assembly
// --------------------------------------------------------------
reg [31:0] status_word;
reg [31:0] ctrl_word;
reg [31:0] mode_word;
reg [31:0] rd_mux;

always @* begin
    status_word = 32'h00000000;
    status_word[`BSS_BIT_66MHZ] = cap_66mhz;
    status_word[`BSS_BIT_FBB] = cap_fbb;
    status_word[`BSS_BIT_MDPE] = flag_vec[`BSS_FLG_MDPE];
    status_word[`BSS_BIT_TSEL_HI:`BSS_BIT_TSEL_LO] = tsel_timing;
    status_word[`BSS_BIT_STA] = flag_vec[`BSS_FLG_STA];
    status_word[`BSS_BIT_RTA] = flag_vec[`BSS_FLG_RTA];
    status_word[`BSS_BIT_RMA] = flag_vec[`BSS_FLG_RMA];
    status_word[`BSS_BIT_RSE] = flag_vec[`BSS_FLG_RSE];
    status_word[`BSS_BIT_DPE] = flag_vec[`BSS_FLG_DPE];
end

always @* begin
    ctrl_word = 32'h00000000;
    ctrl_word[`BSS_BIT_PERR_EN] = parity_resp_en_r;
end

always @* begin
    mode_word = 32'h00000000;
    mode_word[`BSS_BIT_REVERSE] = reverse_mode_r;
    mode_word[`BSS_BIT_SEC_PCIX] = sec_pcix_mode_r;
end

always @* begin
    rd_mux = 32'h00000000;
    case (paddr)
        `BSS_OFF_SEC_STATUS: begin
            rd_mux = status_word;
        end
        `BSS_OFF_BRIDGE_CTRL: begin
            rd_mux = ctrl_word;
        end
        `BSS_OFF_MODE_CFG: begin
            rd_mux = mode_word;
        end
        default: begin
            rd_mux = 32'h00000000;
        end
    endcase
end

// --------------------------------------------------------------
// apb answer: one wait-free access cycle after setup
// --------------------------------------------------------------
reg [31:0] prdata_nxt;
reg pready_nxt;
reg pslverr_nxt;

always @* begin
    prdata_nxt = prdata_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    if (setup_phase) begin
        pready_nxt = 1'b1;
        pslverr_nxt = ~hit_any;
        if (pwrite) begin
            prdata_nxt = 32'h00000000;
        end else begin
            prdata_nxt = rd_mux;
        end
    end else if (access_done) begin
        prdata_nxt = 32'h00000000;
    end else if (psel & penable) begin
        pready_nxt = pready_r;
        pslverr_nxt = pslverr_r;
    end
end

always @(posedge clk or posedge rst) begin
    if (rst) begin
        prdata_r <= 32'h00000000;
        pready_r <= 1'b0;
        pslverr_r <= 1'b0;
    end else begin
        prdata_r <= prdata_nxt;
        pready_r <= pready_nxt;
        pslverr_r <= pslverr_nxt;
    end
end

endmodule

`default_nettype wire

// *** test/bss_top_asserts.sv ***
// concurrent checks on the status block ports
`default_nettype none
`include "bss_regs.vh"
module bss_top_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata_r,
    input wire logic pready_r,
    input wire logic pslverr_r,
    // configuration
    input wire logic parity_resp_en_r,
    input wire logic reverse_mode_r,
    input wire logic sec_pcix_mode_r
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic rd_st;
    logic mapped;
    assign rd_st = pready_r && !pwrite && paddr == `BSS_OFF_SEC_STATUS;
    assign mapped = paddr inside {`BSS_OFF_SEC_STATUS, `BSS_OFF_BRIDGE_CTRL,
        `BSS_OFF_MODE_CFG};
    ready_after_setup_a: assert property (psel && !penable |=> pready_r)
        else $error("no ready after setup");
    ready_one_cycle_a: assert property (pready_r |=> !pready_r)
        else $error("ready longer than one cycle");
    fixed_66mhz_a: assert property (rd_st |-> prdata_r[21])
        else $error("bit 21 not one");
    fast_b2b_a: assert property (rd_st |->
        prdata_r[23] == (!reverse_mode_r && !sec_pcix_mode_r))
        else $error("bit 23 wrong");
    tsel_field_a: assert property (rd_st |->
        prdata_r[26:25] == (reverse_mode_r ? 2'h0 : 2'h1))
        else $error("bits 26:25 wrong");
    reserved_zero_a: assert property (rd_st |->
        prdata_r[22] == 1'b0 && prdata_r[20:0] == 21'h0)
        else $error("reserved bits not zero");
    unmapped_err_a: assert property (psel && !penable && !mapped |=>
        pslverr_r && pready_r && prdata_r == 32'h0)
        else $error("unmapped access not refused");
    perr_en_write_a: assert property (pready_r && penable && pwrite &&
        paddr == `BSS_OFF_BRIDGE_CTRL && pstrb[2] |=>
        parity_resp_en_r == $past(pwdata[16]))
        else $error("parity enable not written");
endmodule
bind bss_top bss_top_asserts i_chk (.*);
`default_nettype wire

// *** test/bss_evt_src.sv ***
// event source standing for the bridge datapaths
`default_nettype none
module bss_evt_src (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // request from the bench
    input wire logic fire,
    input wire logic [15:0] mask,
    // one-cycle event strobes
    output logic [15:0] ev_r
);
    timeunit 1ns;
    timeprecision 100ps;
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            ev_r <= 16'h0;
        else
            ev_r <= fire ? mask : 16'h0;
    end
endmodule
`default_nettype wire

// *** test/bss_top_tb.sv ***
// self-checking bench of the status block
`default_nettype none
`include "bss_regs.vh"
module bss_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, fire = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata_r, q;
    logic [3:0] pstrb = 0;
    logic [15:0] mask = 0, ev;
    logic pready_r, pslverr_r, perr_en, rev_mode, pcix, err;
    int fails = 0, compares = 0;
    localparam logic [7:0] SEC = `BSS_OFF_SEC_STATUS;
    localparam logic [31:0] FWD = 32'h02A0_0000;
    localparam logic [31:0] REV = 32'h0020_0000;
    initial forever #2.5 clk = ~clk;
    bss_evt_src i_src (.clk(clk), .rst(rst), .fire(fire), .mask(mask),
        .ev_r(ev));
    bss_top i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r),
        .fwd_rd_parity_err(ev[0]), .fwd_wr_data_phase(ev[1]),
        .secondary_parity_error_in(ev[2]), .fwd_split_msg_perr(ev[3]),
        .rev_cpl_poisoned(ev[4]), .rev_wr_poisoned(ev[5]),
        .fwd_target_abort_sig(ev[6]), .rev_cpl_abort_sent(ev[7]),
        .fwd_target_abort_det(ev[8]), .rev_cpl_abort_recv(ev[9]),
        .fwd_master_abort(ev[10]), .rev_ur_recv(ev[11]),
        .fwd_sys_err_seen(ev[12]), .rev_err_msg_recv(ev[13]),
        .fwd_parity_err(ev[14]), .rev_poisoned_tlp(ev[15]),
        .parity_resp_en_r(perr_en), .reverse_mode_r(rev_mode),
        .sec_pcix_mode_r(pcix));
    task automatic results;
        $display("fails %0d compares %0d", fails, compares);
        if (fails == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
            fails++;
        end
    endtask
    task automatic xfer(logic w, logic [7:0] a, logic [31:0] d,
        logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready_r !== 1'b1 && ++n < 20);
        chk("pready", 1, pready_r);
        q = prdata_r;
        err = pslverr_r;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e, string n);
        xfer(0, a, 32'h0, 4'hF);
        chk(n, e, q);
    endtask
    task automatic pulse(logic [15:0] m);
        @(posedge clk);
        fire <= 1;
        mask <= m;
        @(posedge clk);
        fire <= 0;
    endtask
    task automatic t_unmapped;
        xfer(1, 8'h10, 32'hFFFF_FFFF, 4'hF);
        chk("wr slverr", 1, err);
        xfer(0, 8'h10, 32'h0, 4'hF);
        chk("rd slverr", 1, err);
        chk("rd data", 0, q);
    endtask
    task automatic t_mdpe(logic [15:0] m, logic [31:0] base);
        pulse(m);
        rd(SEC, base | 32'h0100_0000, "mdpe set");
        xfer(1, SEC, 32'h0100_0000, 4'h8);
        rd(SEC, base, "mdpe clear");
    endtask
    task automatic t_flags(logic rev, logic [31:0] base);
        for (int i = 0; i < 5; i++) begin
            pulse(16'h1 << (6 + 2 * i + !rev));
            rd(SEC, base, "other mode event");
            pulse(16'h1 << (6 + 2 * i + rev));
            rd(SEC, base | (32'h1 << (27 + i)), "flag set");
            xfer(1, SEC, 32'h0, 4'hF);
            xfer(1, SEC, 32'hFFFF_FFFF, 4'h7);
            rd(SEC, base | (32'h1 << (27 + i)), "flag held");
            xfer(1, SEC, 32'h1 << (27 + i), 4'h8);
            rd(SEC, base, "flag clear");
        end
    endtask
    task automatic t_misc;
        xfer(1, `BSS_OFF_BRIDGE_CTRL, 32'h0, 4'hB);
        xfer(1, `BSS_OFF_MODE_CFG, 32'h2, 4'hE);
        rd(`BSS_OFF_MODE_CFG, 32'h1, "mode lane off");
        chk("perr_en lane off", 1, perr_en);
        xfer(1, `BSS_OFF_MODE_CFG, 32'h3, 4'h1);
        rd(SEC, REV, "reverse pcix");
        chk("mode pins", 3, {pcix, rev_mode});
        fork
            xfer(1, SEC, 32'h8000_0000, 4'h8);
            pulse(16'h8000);
        join
        rd(SEC, REV | 32'h8000_0000, "set wins");
        xfer(1, SEC, 32'h8000_0000, 4'h8);
        xfer(1, `BSS_OFF_BRIDGE_CTRL, 32'h0, 4'hF);
        pulse(16'h8010);
        rd(SEC, REV | 32'h8000_0000, "ungated dpe");
        chk("perr_en pin off", 0, perr_en);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 0;
        rd(SEC, FWD, "status reset");
        chk("cfg reset", 0, {perr_en, rev_mode, pcix});
        rd(`BSS_OFF_BRIDGE_CTRL, 32'h0, "ctrl reset");
        t_unmapped;
        pulse(16'h0001);
        rd(SEC, FWD, "gated mdpe");
        xfer(1, `BSS_OFF_BRIDGE_CTRL, 32'h0001_0000, 4'hF);
        rd(`BSS_OFF_BRIDGE_CTRL, 32'h0001_0000, "ctrl");
        chk("perr_en pin", 1, perr_en);
        t_mdpe(16'h0001, FWD);
        t_mdpe(16'h0006, FWD);
        t_mdpe(16'h0008, FWD);
        pulse(16'h0004);
        rd(SEC, FWD, "parity outside write");
        t_flags(0, FWD);
        xfer(1, `BSS_OFF_MODE_CFG, 32'h2, 4'hF);
        rd(SEC, 32'h0220_0000, "pcix mode");
        chk("pcix pins", 2, {pcix, rev_mode});
        xfer(1, `BSS_OFF_MODE_CFG, 32'h1, 4'hF);
        rd(SEC, REV, "reverse mode");
        chk("reverse pins", 1, {pcix, rev_mode});
        t_mdpe(16'h0010, REV);
        t_mdpe(16'h0020, REV);
        t_flags(1, REV);
        t_misc;
        results;
    end
    initial begin
        #20000;
        fails++;
        results;
    end
endmodule
`default_nettype wire
